// ===== fpe_pkg.sv
// package: register map, field layout, codes and timing for the flash command sequencer
package fpe_pkg;
	// register byte offsets (apb, one word each)
	localparam logic [7:0] OFS_CLKDIV   = 8'h00;	// clock divider, bit 7 = loaded
	localparam logic [7:0] OFS_CONFIG   = 8'h04;	// config: wipe pending bit, mode bit
	localparam logic [7:0] OFS_STATUS   = 8'h08;	// flash status register
	localparam logic [7:0] OFS_INDEX    = 8'h0c;	// parameter index
	localparam logic [7:0] OFS_WORD     = 8'h10;	// parameter word at current index
	localparam logic [7:0] OFS_SECURITY = 8'h14;	// security register
	localparam logic [7:0] OFS_PROTECT  = 8'h18;	// protection configuration
	// status field positions
	localparam int ST_CCF  = 7;	// command complete
	localparam int ST_ACC  = 5;	// access error
	localparam int ST_PV   = 4;	// protection violation
	localparam int ST_VE   = 1;	// verify error
	localparam int ST_VU   = 0;	// verify uncorrectable
	// config field positions
	localparam int CF_WIPE = 0;	// wipe pending bit
	localparam int CF_MODE = 1;	// special mode enable (commands allowed)
	// divider loaded flag position
	localparam int DV_LOAD = 7;
	// reset values
	localparam logic [7:0] RST_CLKDIV = 8'h00;
	localparam logic [1:0] RST_SEC    = 2'h2;	// secured
	localparam logic [1:0] SEC_UNSEC  = 2'h1;	// unsecure code
	// command codes and expected parameter index
	localparam logic [7:0] CMD_PGM  = 8'h06;
	localparam logic [7:0] CMD_OTP  = 8'h07;
	localparam logic [7:0] CMD_ERSA = 8'h08;
	localparam logic [2:0] IDX_PGM  = 3'h5;
	localparam logic [2:0] IDX_ERSA = 3'h0;
	localparam logic [2:0] OTP_MAX  = 3'h7;
	// address map
	localparam logic [7:0] PFLASH_HI = 8'h00;	// only valid global address [23:16] value
	// timing: nanoseconds per step and derived cycles at 25 ns
	localparam int CLK_NS     = 25;
	localparam int PGM_NS     = 1000;
	localparam int ERS_NS     = 4000;
	localparam int PGM_CYC    = (PGM_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERS_CYC    = (ERS_NS + CLK_NS - 1) / CLK_NS;
	// sequencer states
	typedef enum logic [2:0] {
		FPE_IDLE,
		FPE_CHECK,
		FPE_BLANK,
		FPE_WORK,
		FPE_VERIFY,
		FPE_DONE
	} fpe_state_e;
	// status group
	typedef struct packed {
		logic ccf;
		logic acc;
		logic pv;
		logic ve;
		logic vu;
	} fpe_stat_s;
endpackage

// ===== fpe_seq.sv
// flash program, one-time-program and erase-all command sequencer with apb registers
//Contract
// - program phrase writes four words, verifies, completes
// - index not 101 raises access error
// - address low three bits nonzero: access error
// - address outside valid range: access error
// - command forbidden in mode: access error
// - protected low address bits: protection violation
// - verify errors set the matching verify flags
// - otp code 07, index 0..7, four words
// - otp blank check, program, verify, then complete
// - otp already programmed phrase: access error
// - all-ones phrase may be programmed again
// - otp index out of range: access error
// - flash reads invalid during otp
// - erase all, verify, release security
// - erase-all index not 000: access error
// - any protection on erase-all: violation
// - wipe request needs loaded divider
// - divider reset after wipe
// - wipe ignores protection, unsecures on pass
// - wipe pending bit shown, cleared at end
// - wipe verify errors set verify flags
// - clearing complete flag launches command
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module fpe_seq #(
	parameter int STEP_CYC = fpe_pkg::ERS_CYC	// cycles per work step, used by program, otp and erase
) (
	input  wire logic        clk_sys_i,	// 40 mhz system clock
	input  wire logic        arst_n_i,	// async reset, active low
	input  wire logic        psel,	// apb select
	input  wire logic        penable,	// apb enable
	input  wire logic        pwrite,	// apb direction
	input  wire logic [7:0]  paddr,	// apb byte address
	input  wire logic [31:0] pwdata,	// apb write data
	output logic      [31:0] prdata,	// apb read data
	output logic             pready,	// apb ready
	output logic             pslverr,	// apb error
	input  wire logic        wipe_req_i,	// pin erase-all request (async)
	input  wire logic        verify_err_i,	// array verify error (same clock)
	input  wire logic        verify_unc_i,	// array uncorrectable error
	output logic             read_invalid_o,	// flash read data invalid
	output logic       [1:0] sec_state_o	// security state field
);
	// elaboration check: step timer is 16 bits wide
	if (STEP_CYC < 1 || STEP_CYC > 65535)
	begin
		$error("STEP_CYC out of range");
	end

	// all state in one struct
	typedef struct packed {
		fpe_pkg::fpe_state_e st;
		logic [7:0]  clkdiv;	// clock divider reg
		logic        mode;	// special mode enable
		logic        wipe;	// wipe pending bit
		logic [2:0]  idx;	// parameter index
		logic [15:0] w0;	// param 0: code and addr hi
		logic [15:0] w1;	// param 1: addr lo / phrase
		logic [63:0] data;	// param words 2..5
		logic [1:0]  sec;	// security state field
		logic        secbyte;	// stored security byte unsecure
		logic [7:0]  prot;	// protection bits, nonzero = protected
		fpe_pkg::fpe_stat_s stat;
		logic [7:0]  otp_used;	// otp phrases programmed
		logic [7:0]  otp_ones;	// otp phrases programmed to all ones
		logic [15:0] cnt;	// step timer
		logic        pin;	// running a pin wipe
		logic [31:0] rd;	// read data
		logic        rdy;	// pready
		logic        err;	// pslverr, registered with pready
		logic        ve;	// latched verify error
		logic        vu;	// latched uncorrectable
		logic        rdinv;	// read invalid
		logic [1:0]  wsync;	// request synchroniser
		logic        wsync_q;	// request previous
	} fpe_state_s;

	fpe_state_s r;
	fpe_state_s next_r;

	// register decode used for reads
	function automatic logic [31:0] read_mux(input fpe_state_s s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		unique case (a)
			fpe_pkg::OFS_CLKDIV:   v[7:0] = s.clkdiv;
			fpe_pkg::OFS_CONFIG:   v[2:0] = {1'b0, s.mode, s.wipe};
			fpe_pkg::OFS_STATUS:   v[7:0] = {s.stat.ccf, 1'b0, s.stat.acc, s.stat.pv,
				2'b00, s.stat.ve, s.stat.vu};
			fpe_pkg::OFS_INDEX:    v[2:0] = s.idx;
			fpe_pkg::OFS_WORD:     unique case (s.idx)
				3'h0:    v[15:0] = s.w0;
				3'h1:    v[15:0] = s.w1;
				3'h2:    v[15:0] = s.data[15:0];
				3'h3:    v[15:0] = s.data[31:16];
				3'h4:    v[15:0] = s.data[47:32];
				3'h5:    v[15:0] = s.data[63:48];
				default: v = 32'h0;
			endcase
			fpe_pkg::OFS_SECURITY: v[2:0] = {s.secbyte, s.sec};
			fpe_pkg::OFS_PROTECT:  v[7:0] = s.prot;
			default:               v = 32'h0;
		endcase
		return v;
	endfunction

	// address is mapped
	function automatic logic mapped(input logic [7:0] a);
		return (a == fpe_pkg::OFS_CLKDIV) || (a == fpe_pkg::OFS_CONFIG) ||
			(a == fpe_pkg::OFS_STATUS) || (a == fpe_pkg::OFS_INDEX) ||
			(a == fpe_pkg::OFS_WORD) || (a == fpe_pkg::OFS_SECURITY) ||
			(a == fpe_pkg::OFS_PROTECT);
	endfunction

	logic       acc_wr;	// apb access phase write
	logic       acc_rd;	// apb access phase read
	logic [7:0] cmd;	// command code
	logic [2:0] ph;	// otp phrase
	logic       wipe_rise;	// synchronised request edge

	// next state
	always_comb
	begin
		next_r = r;
		acc_wr = psel && penable && pwrite && r.rdy;
		acc_rd = psel && penable && !pwrite && r.rdy;
		cmd = r.w0[15:8];
		ph = r.w1[2:0];
		// two-flop synchroniser then edge
		next_r.wsync = {r.wsync[0], wipe_req_i};
		next_r.wsync_q = r.wsync[1];
		wipe_rise = r.wsync[1] && !r.wsync_q;
		// apb: no wait state, ready pulses in the first access phase cycle
		next_r.rdy = psel && !r.rdy;
		// error flag rises with ready so it stands in the same cycle
		next_r.err = psel && !r.rdy && !mapped(paddr);
		if (acc_rd)
			next_r.rd = 32'h0;
		if (psel && !penable)
			next_r.rd = read_mux(r, paddr);
		// register writes
		if (acc_wr)
		begin
			unique case (paddr)
				fpe_pkg::OFS_CLKDIV:  next_r.clkdiv = pwdata[7:0] | 8'h80;
				fpe_pkg::OFS_CONFIG:  next_r.mode = pwdata[fpe_pkg::CF_MODE];
				fpe_pkg::OFS_INDEX:   next_r.idx = pwdata[2:0];
				fpe_pkg::OFS_PROTECT: next_r.prot = pwdata[7:0];
				fpe_pkg::OFS_WORD:    unique case (r.idx)
					3'h0:    next_r.w0 = pwdata[15:0];
					3'h1:    next_r.w1 = pwdata[15:0];
					3'h2:    next_r.data[15:0] = pwdata[15:0];
					3'h3:    next_r.data[31:16] = pwdata[15:0];
					3'h4:    next_r.data[47:32] = pwdata[15:0];
					3'h5:    next_r.data[63:48] = pwdata[15:0];
					default: next_r.w0 = r.w0;
				endcase
				fpe_pkg::OFS_STATUS:
				begin
					// write one clears access error and protection violation flags
					if (pwdata[fpe_pkg::ST_ACC])
						next_r.stat.acc = 1'b0;
					if (pwdata[fpe_pkg::ST_PV])
						next_r.stat.pv = 1'b0;
					// clearing complete launches, only when errors clear
					if (pwdata[fpe_pkg::ST_CCF] && r.stat.ccf && r.st == fpe_pkg::FPE_IDLE
						&& !r.stat.acc && !r.stat.pv)
					begin
						next_r.stat.ccf = 1'b0;
						next_r.st = fpe_pkg::FPE_CHECK;
						next_r.pin = 1'b0;
					end
				end
				default: next_r.idx = r.idx;
			endcase
		end
		// pin wipe request
		if (wipe_rise && r.st == fpe_pkg::FPE_IDLE)
		begin
			next_r.wipe = 1'b1;
			next_r.pin = 1'b1;
			next_r.stat.ccf = 1'b0;
			next_r.st = fpe_pkg::FPE_CHECK;
		end
		// sequencer
		unique case (r.st)
			fpe_pkg::FPE_IDLE:
				next_r.cnt = 16'h0;
			fpe_pkg::FPE_CHECK:
			begin
				next_r.ve = 1'b0;
				next_r.vu = 1'b0;
				next_r.stat.ve = 1'b0;
				next_r.stat.vu = 1'b0;
				next_r.st = fpe_pkg::FPE_DONE;
				if (r.pin)
				begin
					if (!r.clkdiv[fpe_pkg::DV_LOAD])
						next_r.stat.acc = 1'b1;
					else
						next_r.st = fpe_pkg::FPE_WORK;
				end
				else if (!r.mode)
					next_r.stat.acc = 1'b1;
				else if (cmd == fpe_pkg::CMD_PGM)
				begin
					if (r.idx != fpe_pkg::IDX_PGM)
						next_r.stat.acc = 1'b1;
					else if (r.w1[2:0] != 3'h0)
						next_r.stat.acc = 1'b1;
					else if (r.w0[7:0] != fpe_pkg::PFLASH_HI)
						next_r.stat.acc = 1'b1;
					else if (r.prot[r.w1[15:13]])
						next_r.stat.pv = 1'b1;
					else
						next_r.st = fpe_pkg::FPE_WORK;
				end
				else if (cmd == fpe_pkg::CMD_OTP)
				begin
					if (r.idx != fpe_pkg::IDX_PGM)
						next_r.stat.acc = 1'b1;
					else if (r.w1 > {13'h0, fpe_pkg::OTP_MAX})
						next_r.stat.acc = 1'b1;
					else
						next_r.st = fpe_pkg::FPE_BLANK;
				end
				else if (cmd == fpe_pkg::CMD_ERSA)
				begin
					if (r.idx != fpe_pkg::IDX_ERSA)
						next_r.stat.acc = 1'b1;
					else if (r.prot != 8'h00)
						next_r.stat.pv = 1'b1;
					else
						next_r.st = fpe_pkg::FPE_WORK;
				end
				else
					next_r.stat.acc = 1'b1;
			end
			fpe_pkg::FPE_BLANK:
			begin
				// otp blank check; all-ones phrase may repeat
				if (r.otp_used[ph] && !r.otp_ones[ph])
				begin
					next_r.stat.acc = 1'b1;
					next_r.st = fpe_pkg::FPE_DONE;
				end
				else
				begin
					next_r.rdinv = 1'b1;
					next_r.st = fpe_pkg::FPE_WORK;
				end
			end
			fpe_pkg::FPE_WORK:
			begin
				next_r.cnt = r.cnt + 16'h1;
				next_r.ve = r.ve | verify_err_i;
				next_r.vu = r.vu | verify_unc_i;
				if (r.cnt == 16'(STEP_CYC - 1))
				begin
					next_r.cnt = 16'h0;
					next_r.st = fpe_pkg::FPE_VERIFY;
				end
			end
			fpe_pkg::FPE_VERIFY:
			begin
				// read back check, errors latched
				next_r.stat.ve = r.ve | verify_err_i;
				next_r.stat.vu = r.vu | verify_unc_i;
				if (cmd == fpe_pkg::CMD_OTP && !r.pin && !(r.ve | verify_err_i))
				begin
					next_r.otp_used[ph] = 1'b1;
					next_r.otp_ones[ph] = (r.data == 64'hffff_ffff_ffff_ffff)
						&& !r.otp_used[ph];
				end
				if ((r.pin || cmd == fpe_pkg::CMD_ERSA) && !(r.ve | verify_err_i))
				begin
					next_r.sec = fpe_pkg::SEC_UNSEC;
					if (r.pin)
						next_r.secbyte = 1'b1;
				end
				next_r.st = fpe_pkg::FPE_DONE;
			end
			fpe_pkg::FPE_DONE:
			begin
				next_r.stat.ccf = 1'b1;
				next_r.rdinv = 1'b0;
				if (r.pin)
				begin
					next_r.clkdiv = fpe_pkg::RST_CLKDIV;
					next_r.wipe = 1'b0;
					next_r.pin = 1'b0;
				end
				next_r.st = fpe_pkg::FPE_IDLE;
			end
			// unused state codes fall back to idle
			default:
				next_r.st = fpe_pkg::FPE_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			r <= '0;
			r.st <= fpe_pkg::FPE_IDLE;
			r.clkdiv <= fpe_pkg::RST_CLKDIV;
			r.sec <= fpe_pkg::RST_SEC;
			r.stat.ccf <= 1'b1;
		end
		else
			r <= next_r;
	end

	// outputs straight from flops
	assign prdata = r.rd;
	assign pready = r.rdy;
	assign pslverr = r.err;
	assign read_invalid_o = r.rdinv;
	assign sec_state_o = r.sec;

	// assertions
	property p_pgm_idx;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_CHECK && !r.pin && r.mode && cmd == fpe_pkg::CMD_PGM
			&& r.idx != fpe_pkg::IDX_PGM) |=> r.stat.acc;
	endproperty
	a_pgm_idx: assert property (p_pgm_idx) else $error("bad index not flagged");

	property p_align;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_CHECK && !r.pin && r.mode && cmd == fpe_pkg::CMD_PGM
			&& r.w1[2:0] != 3'h0) |=> r.st == fpe_pkg::FPE_DONE ##1 r.stat.ccf;
	endproperty
	a_align: assert property (p_align) else $error("misaligned program ran");

	property p_mode;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_CHECK && !r.pin && !r.mode) |=> r.stat.acc;
	endproperty
	a_mode: assert property (p_mode) else $error("mode error not flagged");

	property p_ersa_prot;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_CHECK && !r.pin && r.mode && cmd == fpe_pkg::CMD_ERSA
			&& r.idx == fpe_pkg::IDX_ERSA && r.prot != 8'h00) |=> r.stat.pv;
	endproperty
	a_ersa_prot: assert property (p_ersa_prot) else $error("protection missed");

	property p_div;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_CHECK && r.pin && !r.clkdiv[fpe_pkg::DV_LOAD])
			|=> r.stat.acc ##1 (r.wipe == 1'b0);
	endproperty
	a_div: assert property (p_div) else $error("wipe ran without divider");

	property p_div_clr;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_DONE && r.pin) |=> (r.clkdiv == fpe_pkg::RST_CLKDIV);
	endproperty
	a_div_clr: assert property (p_div_clr) else $error("divider kept after wipe");

	property p_ccf_work;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_WORK) |-> !r.stat.ccf;
	endproperty
	a_ccf_work: assert property (p_ccf_work) else $error("complete during work");

	property p_unsec;
		@(posedge clk_sys_i) disable iff (!arst_n_i)
		(r.st == fpe_pkg::FPE_VERIFY && r.pin && !r.ve && !verify_err_i)
			|=> sec_state_o == fpe_pkg::SEC_UNSEC ##1 r.stat.ccf;
	endproperty
	a_unsec: assert property (p_unsec) else $error("wipe did not unsecure");
endmodule
`default_nettype wire

// ===== fpe_seq_tb.sv
// self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fpe_seq_tb;
	// one queued read expectation
	typedef struct packed
	{
		logic [7:0]  a;
		logic [31:0] e;
		logic [31:0] m;
		logic        r;
	} fpe_note_s;
	// short aliases of the register offsets
	localparam logic [7:0] A_DIV = fpe_pkg::OFS_CLKDIV;
	localparam logic [7:0] A_CFG = fpe_pkg::OFS_CONFIG;
	localparam logic [7:0] A_ST  = fpe_pkg::OFS_STATUS;
	localparam logic [7:0] A_PR  = fpe_pkg::OFS_PROTECT;
	logic        clk_sys_i    = 1'b0;	// 40 mhz clock
	logic        arst_n_i     = 1'b0;	// reset, active low
	logic        psel         = 1'b0;	// apb select
	logic        penable      = 1'b0;	// apb enable
	logic        pwrite       = 1'b0;	// apb direction
	logic [7:0]  paddr        = 8'h00;	// apb address
	logic [31:0] pwdata       = 32'h0;	// apb write data
	logic [31:0] prdata;	// apb read data
	logic        pready;	// apb ready
	logic        pslverr;	// apb error
	logic        wipe_req_i   = 1'b0;	// pin erase-all request
	logic        verify_err_i = 1'b0;	// verify error input
	logic        verify_unc_i = 1'b0;	// uncorrectable input
	logic        read_invalid_o;	// flash reads invalid
	logic [1:0]  sec_state_o;	// security field
	logic [31:0] rd;	// last read data
	logic [15:0] dat;	// random program data
	int          error_cnt   = 0;	// mismatches
	int          checks_done = 0;	// comparisons
	int          inv_cnt     = 0;	// cycles with flash reads invalid
	fpe_note_s   notes[$];	// pending read expectations
	fpe_note_s   nt;	// note under test
	// clock
	always #12.5 clk_sys_i = ~clk_sys_i;
	// device, short work steps for every command
	fpe_seq #(.STEP_CYC(4)) i_fpe_seq (
		.clk_sys_i     (clk_sys_i),
		.arst_n_i      (arst_n_i),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.wipe_req_i    (wipe_req_i),
		.verify_err_i  (verify_err_i),
		.verify_unc_i  (verify_unc_i),
		.read_invalid_o(read_invalid_o),
		.sec_state_o   (sec_state_o)
	);
	// compare and count
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		// wait for ready; only the watchdog ends a hang
		do
			@(posedge clk_sys_i);
		while (pready !== 1'b1);
		rd      = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// read with expected value, mask and error
	task automatic rdx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic r);
		notes.push_back('{a, e, m, r});
		apb(1'b0, a, 32'h0);
	endtask
	// poll one bit until it reaches a level
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		int n;
		n = 0;
		do
		begin
			rdx(a, 32'h0, 32'h0, 1'b0);
			n++;
		end
		while (rd[b] !== v && n < 300);
		if (n >= 300)
			cmp("poll", {31'h0, v}, {31'h0, rd[b]});
	endtask
	// load parameters, launch, wait, check and clear status
	task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] d,
		input logic [2:0] ix, input logic [7:0] est);
		for (int i = 0; i < 6; i++)
		begin
			wr(fpe_pkg::OFS_INDEX, i);
			wr(fpe_pkg::OFS_WORD, {16'h0, (i == 0) ? w0 : (i == 1) ? w1 : d});
		end
		wr(fpe_pkg::OFS_INDEX, {29'h0, ix});
		wr(A_ST, 32'h80);
		poll(A_ST, fpe_pkg::ST_CCF, 1'b1);
		rdx(A_ST, {24'h0, est}, 32'hb3, 1'b0);
		wr(A_ST, 32'h30);
	endtask
	// pin erase-all, pending bit up then down
	task automatic wipe(input logic [7:0] est);
		wipe_req_i <= 1'b1;
		poll(A_CFG, fpe_pkg::CF_WIPE, 1'b1);
		wipe_req_i <= 1'b0;
		poll(A_CFG, fpe_pkg::CF_WIPE, 1'b0);
		rdx(A_ST, {24'h0, est}, 32'hb3, 1'b0);
	endtask
	// monitor: each read answer against the oldest note
	always @(posedge clk_sys_i)
	begin
		if (read_invalid_o === 1'b1)
			inv_cnt++;
		if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0)
		begin
			nt = notes.pop_front();
			cmp($sformatf("rdata@%h", nt.a), nt.e & nt.m, prdata & nt.m);
			cmp("pslverr", {31'h0, nt.r}, {31'h0, pslverr});
		end
	end
	// watchdog
	initial
	begin
		#1500000;
		error_cnt++;
		report_and_stop();
	end
	// main sequence
	initial
	begin
		dat = 16'($urandom(14578));
		repeat (3) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		rdx(A_ST, 32'h80, 32'hb3, 1'b0);
		rdx(A_DIV, 32'h0, 32'hff, 1'b0);
		rdx(8'h40, 32'h0, 32'hffffffff, 1'b1);
		cmp("sec", 32'h2, {30'h0, sec_state_o});
		$display("test reset values done");
		wr(A_DIV, 32'h0f);
		wr(A_CFG, 32'h2);
		dat = 16'($urandom) & 16'h7fff;	// never all ones
		run({fpe_pkg::CMD_PGM, 8'h00}, 16'h0100, dat, 3'h5, 8'h80);
		run({fpe_pkg::CMD_PGM, 8'h00}, 16'h0100, dat, 3'h4, 8'ha0);
		run({fpe_pkg::CMD_PGM, 8'h00}, 16'h0100 + 16'($urandom_range(1, 7)), dat, 3'h5, 8'ha0);
		run({fpe_pkg::CMD_PGM, 8'($urandom_range(1, 255))}, 16'h0100, dat, 3'h5, 8'ha0);
		wr(A_PR, 32'h4);
		run({fpe_pkg::CMD_PGM, 8'h00}, 16'h4008, dat, 3'h5, 8'h90);
		verify_err_i <= 1'b1;
		verify_unc_i <= 1'b1;
		run({fpe_pkg::CMD_PGM, 8'h00}, 16'h0200, dat, 3'h5, 8'h83);
		verify_err_i <= 1'b0;
		verify_unc_i <= 1'b0;
		wr(A_CFG, 32'h0);
		run({fpe_pkg::CMD_PGM, 8'h00}, 16'h0300, dat, 3'h5, 8'ha0);
		run({fpe_pkg::CMD_OTP, 8'h00}, 16'h0000, dat, 3'h5, 8'ha0);
		run({fpe_pkg::CMD_ERSA, 8'h00}, 16'h0000, dat, 3'h0, 8'ha0);
		wr(A_CFG, 32'h2);
		$display("test program phrase done");
		run({fpe_pkg::CMD_OTP, 8'h00}, 16'h0002, dat | 16'h1, 3'h5, 8'h80);
		cmp("read_invalid", 32'h1, {31'h0, inv_cnt != 0});
		cmp("read_invalid", 32'h0, {31'h0, read_invalid_o});
		run({fpe_pkg::CMD_OTP, 8'h00}, 16'h0002, dat | 16'h1, 3'h5, 8'ha0);
		run({fpe_pkg::CMD_OTP, 8'h00}, 16'h0003, 16'hffff, 3'h5, 8'h80);
		run({fpe_pkg::CMD_OTP, 8'h00}, 16'h0003, dat | 16'h1, 3'h5, 8'h80);
		for (int i = 4; i < 8; i++)
			run({fpe_pkg::CMD_OTP, 8'h00}, 16'(i), dat, 3'h5, 8'h80);
		run({fpe_pkg::CMD_OTP, 8'h00}, 16'h0008, dat, 3'h5, 8'ha0);
		$display("test one-time program done");
		run({fpe_pkg::CMD_ERSA, 8'h00}, 16'h0000, dat, 3'h1, 8'ha0);
		run({fpe_pkg::CMD_ERSA, 8'h00}, 16'h0000, dat, 3'h0, 8'h90);
		wr(A_PR, 32'h0);
		verify_err_i <= 1'b1;
		run({fpe_pkg::CMD_ERSA, 8'h00}, 16'h0000, dat, 3'h0, 8'h82);
		verify_err_i <= 1'b0;
		cmp("sec", 32'h2, {30'h0, sec_state_o});
		run({fpe_pkg::CMD_ERSA, 8'h00}, 16'h0000, dat, 3'h0, 8'h80);
		cmp("sec", 32'h1, {30'h0, sec_state_o});
		$display("test erase all done");
		// second reset: secured again, divider not loaded
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		cmp("sec", 32'h2, {30'h0, sec_state_o});
		wipe_req_i <= 1'b1;
		poll(A_ST, fpe_pkg::ST_ACC, 1'b1);
		wipe_req_i <= 1'b0;
		cmp("sec", 32'h2, {30'h0, sec_state_o});
		wr(A_ST, 32'h30);
		wr(A_PR, 32'hff);
		wr(A_DIV, 32'h0f);
		verify_err_i <= 1'b1;
		verify_unc_i <= 1'b1;
		wipe(8'h83);
		verify_err_i <= 1'b0;
		verify_unc_i <= 1'b0;
		cmp("sec", 32'h2, {30'h0, sec_state_o});
		wr(A_DIV, 32'h0f);
		wipe(8'h80);
		cmp("sec", 32'h1, {30'h0, sec_state_o});
		rdx(A_DIV, 32'h0, 32'hff, 1'b0);
		rdx(A_PR, 32'hff, 32'hff, 1'b0);
		rdx(fpe_pkg::OFS_SECURITY, 32'h5, 32'h7, 1'b0);
		$display("test erase-all pin done");
		report_and_stop();
	end
endmodule
`default_nettype wire
